// ---- hdl/backlight_dimming_config_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module backlight_dimming_config_regs (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // register port from the serial bus decoder
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic addr_hit_out,
  // low brightness bits written at the neighbouring register
  input wire logic low_bits_write_in,
  input wire logic [3:0] low_bits_in,
  // nonvolatile store image
  input wire logic nv_valid_in,
  input wire logic [31:0] nv_image_in,
  output logic nv_reload_out,
  // decoded controls
  output logic [11:0] brightness_code_out,
  output logic external_fullscale_select_out,
  output logic [1:0] short_detect_threshold_out,
  output logic [1:0] analog_pwm_crossover_out,
  output logic pure_pwm_out,
  output logic [2:0] pwm_dim_frequency_out,
  output logic pwm_freq_reserved_out,
  output logic standby_out,
  output logic [1:0] dimming_source_out,
  output logic dither_enable_out,
  output logic [14:0] resolution_bits_out,
  output logic [1:0] smoothing_filter_out,
  output logic [2:0] pwm_input_filter_out
);
  // =====================================
  // register storage
  logic [7:0] bright_high;
  logic [7:0] dim_ctrl;
  logic [7:0] power_ctrl;
  logic [7:0] filter_ctrl;
  logic [3:0] low_pending;
  logic [3:0] low_applied;
  logic reload_req;
  logic wr_hit;
  // soft reset is a command, never a stored state, so an image cannot re-arm it
  localparam logic [7:0] SOFT_RESET_MASK = 8'h01 << dim_cfg_pkg::SOFT_RESET_BIT;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == dim_cfg_pkg::ADDR_BRIGHT_HIGH) || (a == dim_cfg_pkg::ADDR_DIM_CTRL) ||
      (a == dim_cfg_pkg::ADDR_POWER_CTRL) || (a == dim_cfg_pkg::ADDR_FILTER_CTRL);
  endfunction

  assign wr_hit = wr_en_in && is_mapped(addr_in);
  assign addr_hit_out = (wr_en_in || rd_en_in) && is_mapped(addr_in);

  // reset or soft reset triggers a reload; a fresh image clears it; standby never does
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reload_req <= 1'b1;
    end else if (wr_en_in && addr_in == dim_cfg_pkg::ADDR_POWER_CTRL && wdata_in[dim_cfg_pkg::SOFT_RESET_BIT]) begin
      reload_req <= 1'b1;
    end else if (nv_valid_in) begin
      reload_req <= 1'b0;
    end
  end
  assign nv_reload_out = reload_req;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bright_high <= dim_cfg_pkg::DEF_BRIGHT_HIGH;
      dim_ctrl <= dim_cfg_pkg::DEF_DIM_CTRL;
      power_ctrl <= dim_cfg_pkg::DEF_POWER_CTRL;
      filter_ctrl <= dim_cfg_pkg::DEF_FILTER_CTRL;
    end else if (wr_en_in && addr_in == dim_cfg_pkg::ADDR_POWER_CTRL && wdata_in[dim_cfg_pkg::SOFT_RESET_BIT]) begin
      // clear the four registers first (low bits kept), image follows
      bright_high <= '0;
      dim_ctrl <= '0;
      power_ctrl <= '0;
      filter_ctrl <= '0;
    end else if (reload_req && nv_valid_in) begin
      bright_high <= nv_image_in[7:0];
      dim_ctrl <= nv_image_in[15:8];
      power_ctrl <= nv_image_in[23:16] & dim_cfg_pkg::POWER_MASK & ~SOFT_RESET_MASK;
      filter_ctrl <= nv_image_in[31:24];
    end else if (wr_en_in) begin
      if (addr_in == dim_cfg_pkg::ADDR_BRIGHT_HIGH) begin
        bright_high <= wdata_in;
      end else if (addr_in == dim_cfg_pkg::ADDR_DIM_CTRL) begin
        dim_ctrl <= wdata_in;
      end else if (addr_in == dim_cfg_pkg::ADDR_POWER_CTRL) begin
        power_ctrl <= wdata_in & dim_cfg_pkg::POWER_MASK;
      end else if (addr_in == dim_cfg_pkg::ADDR_FILTER_CTRL) begin
        filter_ctrl <= wdata_in;
      end
    end
  end

  // low bits are staged and only take effect on a later register write
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_pending <= 4'h0;
      low_applied <= 4'h0;
    end else begin
      if (low_bits_write_in) begin
        low_pending <= low_bits_in;
      end
      if (wr_hit && !low_bits_write_in) begin
        low_applied <= low_pending;
      end
    end
  end

  // =====================================
  // readback
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_en_in) begin
      if (addr_in == dim_cfg_pkg::ADDR_BRIGHT_HIGH) begin
        rdata_out <= bright_high;
      end else if (addr_in == dim_cfg_pkg::ADDR_DIM_CTRL) begin
        rdata_out <= dim_ctrl;
      end else if (addr_in == dim_cfg_pkg::ADDR_POWER_CTRL) begin
        rdata_out <= power_ctrl & dim_cfg_pkg::POWER_MASK;
      end else if (addr_in == dim_cfg_pkg::ADDR_FILTER_CTRL) begin
        rdata_out <= filter_ctrl;
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end

  // =====================================
  // decoded fields
  assign brightness_code_out = {bright_high, low_applied};
  assign external_fullscale_select_out = dim_ctrl[dim_cfg_pkg::EXT_FS_BIT];
  assign short_detect_threshold_out = dim_ctrl[dim_cfg_pkg::SHORT_HI:dim_cfg_pkg::SHORT_LO];
  assign analog_pwm_crossover_out = dim_ctrl[dim_cfg_pkg::XOVER_HI:dim_cfg_pkg::XOVER_LO];
  assign pure_pwm_out = &dim_ctrl[dim_cfg_pkg::XOVER_HI:dim_cfg_pkg::XOVER_LO];
  assign pwm_dim_frequency_out = dim_ctrl[dim_cfg_pkg::FREQ_HI:dim_cfg_pkg::FREQ_LO];
  // reserved codes are flagged so the generator can hold its last valid rate
  assign pwm_freq_reserved_out = pwm_dim_frequency_out > dim_cfg_pkg::FREQ_MAX_CODE;
  assign standby_out = power_ctrl[dim_cfg_pkg::STANDBY_BIT];
  assign dimming_source_out = filter_ctrl[dim_cfg_pkg::SRC_HI:dim_cfg_pkg::SRC_LO];
  assign dither_enable_out = filter_ctrl[dim_cfg_pkg::DITHER_BIT];
  // 15 bits with dither, 12 bits without; selected by dither_enable_out
  assign resolution_bits_out = dither_enable_out ? 15'h7FFF : 15'h0FFF;
  assign smoothing_filter_out = filter_ctrl[dim_cfg_pkg::SMOOTH_HI:dim_cfg_pkg::SMOOTH_LO];
  assign pwm_input_filter_out = filter_ctrl[dim_cfg_pkg::PWMF_HI:dim_cfg_pkg::PWMF_LO];

  // =====================================
  // checks
  property p_high_write;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_en_in && addr_in == dim_cfg_pkg::ADDR_BRIGHT_HIGH && !reload_req)
      |=> brightness_code_out[11:4] == $past(wdata_in);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high brightness byte not stored");

  property p_low_deferred;
    @(posedge ref_clk_in) disable iff (rst_in)
    (low_bits_write_in && !wr_hit) |=> low_applied == $past(low_applied);
  endproperty
  a_low_deferred: assert property (p_low_deferred) else $error("low bits applied too early");

  property p_low_applied;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_hit && !low_bits_write_in) |=> brightness_code_out[3:0] == $past(low_pending);
  endproperty
  a_low_applied: assert property (p_low_applied) else $error("low bits not applied on write");

  property p_reload;
    @(posedge ref_clk_in) disable iff (rst_in)
    (reload_req && nv_valid_in && !wr_en_in) |=> dim_ctrl == $past(nv_image_in[15:8]) && !reload_req;
  endproperty
  a_reload: assert property (p_reload) else $error("image not loaded");

  property p_soft_reset;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_en_in && addr_in == dim_cfg_pkg::ADDR_POWER_CTRL && wdata_in[dim_cfg_pkg::SOFT_RESET_BIT])
      |=> nv_reload_out && bright_high == 8'h00 && filter_ctrl == 8'h00;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not clear");

  property p_standby_keeps;
    @(posedge ref_clk_in) disable iff (rst_in)
    (standby_out && !wr_en_in && !reload_req) |=> $stable(dim_ctrl) && !nv_reload_out;
  endproperty
  a_standby_keeps: assert property (p_standby_keeps) else $error("standby disturbed registers");

  property p_reserved_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_en_in && addr_in == dim_cfg_pkg::ADDR_POWER_CTRL) |=> rdata_out[5:0] == 6'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  property p_freq_reserved;
    @(posedge ref_clk_in) disable iff (rst_in)
    pwm_freq_reserved_out == (dim_ctrl[2:0] >= 3'h5);
  endproperty
  a_freq_reserved: assert property (p_freq_reserved) else $error("reserved frequency flag wrong");

  property p_pure_pwm;
    @(posedge ref_clk_in) disable iff (rst_in)
    pure_pwm_out == (dim_ctrl[4:3] == 2'h3);
  endproperty
  a_pure_pwm: assert property (p_pure_pwm) else $error("pure pwm flag wrong");
endmodule
`default_nettype wire

// ---- shared/dim_cfg_pkg.sv ----
`default_nettype none
package dim_cfg_pkg;
  // =====================================
  // register offsets
  localparam logic [7:0] ADDR_BRIGHT_HIGH = 8'h06;
  localparam logic [7:0] ADDR_DIM_CTRL = 8'h07;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h08;
  localparam logic [7:0] ADDR_FILTER_CTRL = 8'h09;
  // =====================================
  // field positions
  localparam int EXT_FS_BIT = 7;
  localparam int SHORT_HI = 6;
  localparam int SHORT_LO = 5;
  localparam int XOVER_HI = 4;
  localparam int XOVER_LO = 3;
  localparam int FREQ_HI = 2;
  localparam int FREQ_LO = 0;
  localparam int STANDBY_BIT = 7;
  localparam int SOFT_RESET_BIT = 6;
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 6;
  localparam int DITHER_BIT = 5;
  localparam int SMOOTH_HI = 4;
  localparam int SMOOTH_LO = 3;
  localparam int PWMF_HI = 2;
  localparam int PWMF_LO = 0;
  localparam logic [7:0] POWER_MASK = 8'hC0;
  // =====================================
  // factory defaults, used until a nonvolatile image is loaded
  localparam logic [7:0] DEF_BRIGHT_HIGH = 8'h00;
  localparam logic [7:0] DEF_DIM_CTRL = 8'h08;
  localparam logic [7:0] DEF_POWER_CTRL = 8'h00;
  localparam logic [7:0] DEF_FILTER_CTRL = 8'h24;
  localparam logic [2:0] FREQ_MAX_CODE = 3'h4;
  localparam logic [1:0] SRC_PRODUCT = 2'h2;
  // =====================================
  // decoded settings
  typedef enum logic [1:0] {SRC_PWM_ONLY, SRC_SERIAL_ONLY, SRC_PWM_TIMES_SERIAL, SRC_RESERVED} dim_source_e;
endpackage
`default_nettype wire

// ---- testbench/nv_store_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// =====================================
// nonvolatile store: answers a reload request one cycle late
module nv_store_model #(
  parameter logic [31:0] IMAGE = 32'h4C00_1A37
) (
  input wire logic ref_clk_in,
  input wire logic ready_in,
  input wire logic reload_in,
  output logic nv_valid_out,
  output logic [31:0] nv_image_out
);
  always_ff @(posedge ref_clk_in) begin
    nv_valid_out <= ready_in & reload_in;
  end
  // outside a valid answer the image lines carry junk, not the last value
  assign nv_image_out = nv_valid_out ? IMAGE : ~IMAGE;
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // =====================================
  // signals
  logic ref_clk_in = 0, rst_in = 1, wr_en_in = 0, rd_en_in = 0, low_bits_write_in = 0, nv_ready = 0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
  logic [3:0] low_bits_in = 4'h0;
  logic nv_valid_in, nv_reload_out, addr_hit_out, external_fullscale_select_out, pure_pwm_out;
  logic pwm_freq_reserved_out, standby_out, dither_enable_out;
  logic [31:0] nv_image_in;
  logic [11:0] brightness_code_out;
  logic [1:0] short_detect_threshold_out, analog_pwm_crossover_out, dimming_source_out, smoothing_filter_out;
  logic [2:0] pwm_dim_frequency_out, pwm_input_filter_out, v;
  logic [14:0] resolution_bits_out;
  int errors = 0, samples_checked = 0, cycles = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  backlight_dimming_config_regs u_backlight_dimming_config_regs (.ref_clk_in, .rst_in, .wr_en_in,
    .rd_en_in, .addr_in, .wdata_in, .rdata_out, .addr_hit_out, .low_bits_write_in, .low_bits_in,
    .nv_valid_in, .nv_image_in, .nv_reload_out, .brightness_code_out, .external_fullscale_select_out,
    .short_detect_threshold_out, .analog_pwm_crossover_out, .pure_pwm_out, .pwm_dim_frequency_out,
    .pwm_freq_reserved_out, .standby_out, .dimming_source_out, .dither_enable_out,
    .resolution_bits_out, .smoothing_filter_out, .pwm_input_filter_out);
  nv_store_model u_nv_store_model (.ref_clk_in, .ready_in(nv_ready), .reload_in(nv_reload_out),
    .nv_valid_out(nv_valid_in), .nv_image_out(nv_image_in));
  // =====================================
  // tasks
  task automatic final_report();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_en_in <= 1;
    @(posedge ref_clk_in);
    wr_en_in <= 0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_en_in <= 1;
    #1;
    chk(addr_hit_out, a >= dim_cfg_pkg::ADDR_BRIGHT_HIGH && a <= dim_cfg_pkg::ADDR_FILTER_CTRL);
    @(posedge ref_clk_in);
    rd_en_in <= 0;
    #1;
    chk(rdata_out, e);
  endtask
  // a hang ends the run as a failure
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
  // =====================================
  // tests
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 0;
    #1;
    chk(nv_reload_out, 1);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h08);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h24);
    rd(8'h0A, 8'h00);
    // store comes ready: its image replaces the defaults
    @(posedge ref_clk_in);
    nv_ready <= 1;
    for (int i = 0; i < 10 && nv_reload_out; i++) begin
      @(posedge ref_clk_in);
      #1;
    end
    chk(nv_reload_out, 0);
    rd(8'h06, 8'h37);
    rd(8'h07, 8'h1A);
    rd(8'h09, 8'h4C);
    @(posedge ref_clk_in);
    low_bits_write_in <= 1;
    low_bits_in <= 4'h5;
    @(posedge ref_clk_in);
    low_bits_write_in <= 0;
    #1;
    chk(brightness_code_out, 12'h370);
    wr(8'h06, 8'hAB);
    chk(brightness_code_out, 12'hAB5);
    rd(8'h06, 8'hAB);
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      wr(8'h07, {v[0], v[1:0], v[1:0], v});
      chk(external_fullscale_select_out, v[0]);
      chk(short_detect_threshold_out, v[1:0]);
      chk(analog_pwm_crossover_out, v[1:0]);
      chk(pure_pwm_out, v[1:0] == 2'h3);
      chk(pwm_dim_frequency_out, v);
      chk(pwm_freq_reserved_out, v > 3'h4);
      wr(8'h09, {v[1:0], v[0], v[1:0], v});
      chk(dimming_source_out, v[1:0]);
      chk(dither_enable_out, v[0]);
      chk(resolution_bits_out, v[0] ? 15'h7FFF : 15'h0FFF);
      chk(smoothing_filter_out, v[1:0]);
      chk(pwm_input_filter_out, v);
    end
    wr(8'h08, 8'hBF);
    rd(8'h08, 8'h80);
    chk(standby_out, 1);
    chk(nv_reload_out, 0);
    rd(8'h06, 8'hAB);
    wr(8'h08, 8'h40);
    chk(nv_reload_out, 1);
    chk(dimming_source_out, 2'h0);
    chk(standby_out, 0);
    for (int i = 0; i < 10 && nv_reload_out; i++) begin
      @(posedge ref_clk_in);
      #1;
    end
    chk(nv_reload_out, 0);
    rd(8'h06, 8'h37);
    rd(8'h07, 8'h1A);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h4C);
    final_report();
  end
endmodule
`default_nettype wire
